// [hdl/hbridge_pwm_unit.sv]
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ns
module hbridge_pwm_unit
	import pwm_pkg::*;
(
	input wire logic I_REF_CLK,
	input wire logic I_RST_N,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	output logic [31:0] O_HRDATA,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	input wire logic I_SYNC,
	input wire logic I_TRIP_N,
	output logic [NUM_OUT-1:0] O_PWM,
	output logic O_TRIP_IRQ
);

	// Bus data phase state
	logic dp_wr; // A write is in its data phase
	logic next_dp_wr;
	logic [31:0] dp_addr; // Address captured in the address phase
	logic [31:0] next_dp_addr;
	logic [31:0] hrdata; // Read data, registered in the address phase
	logic [31:0] next_hrdata;
	logic take; // Address phase accepted this cycle

	// Software-visible state
	logic [15:0] ctrl; // Modulator control register
	logic [15:0] next_ctrl;
	logic [NUM_PAIRS-1:0][NUM_COMP-1:0][TIMER_W-1:0] com_reg; // Programmed compare values
	logic [NUM_PAIRS-1:0][NUM_COMP-1:0][TIMER_W-1:0] next_com_reg;
	logic [NUM_PAIRS-1:0][TIMER_W-1:0] len_reg; // Period lengths
	logic [NUM_PAIRS-1:0][TIMER_W-1:0] next_len_reg;
	logic trip_pend; // Sticky trip interrupt
	logic next_trip_pend;

	// Decode helpers
	logic [31:0] rd_off; // Read offset into the pair window
	logic [31:0] wr_off; // Write offset into the pair window
	logic rd_pair_hit;
	logic wr_pair_hit;
	logic [1:0] rd_pidx;
	logic [1:0] rd_ridx;
	logic [1:0] wr_pidx;
	logic [1:0] wr_ridx;
	logic clri_wr; // Write to the trip clear register
	logic trip_hit; // Trip condition seen this cycle

	// Prescaler
	logic [DIV_W-1:0] div_cnt; // Free running divider
	logic [DIV_W-1:0] next_div_cnt;
	logic [DIV_W-1:0] pre_mask; // Low bits that must all be set for a step
	logic tick; // One-cycle step of the timers

	// Sync detector
	logic sync_prev; // Sync pin one cycle ago
	logic next_sync_prev;
	logic sync_clear; // Counter restart pulse
	logic next_sync_clear;
	logic sync_fall;

	// Output stage
	logic [NUM_OUT-1:0] raw; // Pair waveforms after per-output inversion
	logic [NUM_OUT-1:0] pwm;
	logic [NUM_OUT-1:0] next_pwm;
	logic [NUM_PAIRS-1:0] hs_v; // High sides of the pairs
	logic [NUM_PAIRS-1:0] ls_v; // Low sides of the pairs
	logic [NUM_PAIRS-1:0] inv_odd; // Invert bits of outputs 5, 3, 1

	// Address decode for both bus phases
	always_comb
	begin
		take = I_HSEL && I_HTRANS[HTRANS_ACT_BIT] && I_HREADY;
		rd_off = I_HADDR - PAIR_BASE;
		wr_off = dp_addr - PAIR_BASE;
		// Only word aligned offsets inside the window map; the rest read as zero
		rd_pair_hit = (rd_off < PAIR_SPAN) && (rd_off[ALIGN_MSB:0] == 2'h0);
		wr_pair_hit = (wr_off < PAIR_SPAN) && (wr_off[ALIGN_MSB:0] == 2'h0);
		rd_pidx = rd_off[PIDX_MSB:PIDX_LSB];
		rd_ridx = rd_off[RIDX_MSB:RIDX_LSB];
		wr_pidx = wr_off[PIDX_MSB:PIDX_LSB];
		wr_ridx = wr_off[RIDX_MSB:RIDX_LSB];
		clri_wr = dp_wr && (dp_addr == CLRI_ADDR);
		trip_hit = ctrl[BIT_TRIP] && !I_TRIP_N;
	end

	// Next values of the bus phase and the register file
	always_comb
	begin
		next_dp_wr = take && I_HWRITE;
		next_dp_addr = take ? I_HADDR : dp_addr;
		next_hrdata = hrdata;
		if (take && !I_HWRITE)
		begin
			// Read data come from the registers as they stand in the address phase
			next_hrdata = 32'h00000000;
			if (I_HADDR == CTRL_ADDR)
			begin
				next_hrdata[15:0] = ctrl;
			end
			else if (I_HADDR == STATUS_ADDR)
			begin
				next_hrdata[BIT_TRIP_PEND] = trip_pend;
			end
			else if (rd_pair_hit)
			begin
				if (rd_ridx == LEN_IDX)
				begin
					next_hrdata[15:0] = len_reg[rd_pidx];
				end
				else
				begin
					next_hrdata[15:0] = com_reg[rd_pidx][rd_ridx];
				end
			end
		end
		next_ctrl = ctrl;
		next_com_reg = com_reg;
		next_len_reg = len_reg;
		if (dp_wr)
		begin
			if (dp_addr == CTRL_ADDR)
			begin
				// Reserved bit kept at zero even if software writes it
				next_ctrl = I_HWDATA[15:0] & CTRL_WMASK;
			end
			else if (wr_pair_hit)
			begin
				if (wr_ridx == LEN_IDX)
				begin
					next_len_reg[wr_pidx] = I_HWDATA[15:0];
				end
				else
				begin
					next_com_reg[wr_pidx][wr_ridx] = I_HWDATA[15:0];
				end
			end
		end
		if (trip_hit)
		begin
			// Trip overrides a software write of the enable bit in the same cycle
			next_ctrl[BIT_EN] = 1'h0;
		end
		next_trip_pend = trip_pend;
		if (clri_wr)
		begin
			next_trip_pend = 1'h0;
		end
		if (trip_hit)
		begin
			// A trip in the clearing cycle is not lost
			next_trip_pend = 1'h1;
		end
	end

	// Bus and register file registers
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			dp_wr <= 1'h0;
			dp_addr <= 32'h00000000;
			hrdata <= 32'h00000000;
			ctrl <= CTRL_RESET;
			com_reg <= '0;
			len_reg <= '0;
			trip_pend <= 1'h0;
		end
		else
		begin
			dp_wr <= next_dp_wr;
			dp_addr <= next_dp_addr;
			hrdata <= next_hrdata;
			ctrl <= next_ctrl;
			com_reg <= next_com_reg;
			len_reg <= next_len_reg;
			trip_pend <= next_trip_pend;
		end
	end

	// Prescaler and sync edge detection
	always_comb
	begin
		next_div_cnt = div_cnt + DIV_ONE;
		// Code n needs n+1 low bits set, giving a step every 2^(n+1) clocks
		pre_mask = DIV_ALL >> (PRE_MAX - ctrl[PRE_MSB:PRE_LSB]);
		tick = ((div_cnt & pre_mask) == pre_mask);
		next_sync_prev = I_SYNC;
		sync_fall = sync_prev && !I_SYNC;
		next_sync_clear = sync_fall && ctrl[BIT_SYNC];
	end

	// Prescaler and sync registers
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			div_cnt <= '0;
			sync_prev <= 1'h1;
			sync_clear <= 1'h0;
		end
		else
		begin
			div_cnt <= next_div_cnt;
			sync_prev <= next_sync_prev;
			sync_clear <= next_sync_clear;
		end
	end

	// One timer and edge generator per output pair
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PAIRS; gp++)
		begin : g_pair
			pair_if pif();
			// Timers stop while the unit is disabled
			assign pif.tick = tick && ctrl[BIT_EN];
			assign pif.sync_clear = sync_clear;
			assign pif.load_req = ctrl[BIT_LOAD_COMPARE_REQ];
			assign pif.com = com_reg[gp];
			assign pif.len = len_reg[gp];
			assign hs_v[gp] = pif.hs;
			assign ls_v[gp] = pif.ls;
			pwm_pair u_pair (
				.i_clk(I_REF_CLK),
				.i_rst_n(I_RST_N),
				.pio(pif.pair)
			);
			assign raw[2*gp] = hs_v[gp];
			assign raw[2*gp+1] = ls_v[gp] ^ inv_odd[gp];
		end
	endgenerate

	assign inv_odd = {ctrl[BIT_INV5], ctrl[BIT_INV3], ctrl[BIT_INV1]};

	// Output selection for standard and bridge modes
	always_comb
	begin
		next_pwm = ctrl[BIT_EN] ? raw : '0;
		if (ctrl[BIT_BRIDGE_MODE_ENABLE])
		begin
			// Bridge mode takes over bits 0..3; outputs 4 and 5 keep their pair waveform, inverted when GLOBAL_OUTPUT_INVERT is set
			next_pwm[5:4] = raw[5:4] ^ {2{ctrl[BIT_GLOBAL_OUTPUT_INVERT]}};
			if (ctrl[BIT_HIGH_SIDE_OFF])
			begin
				next_pwm[3:0] = BR_HIGH_SIDE_OFF;
			end
			else if (!ctrl[BIT_ENA])
			begin
				next_pwm[3:0] = BR_ALL_HIGH;
			end
			else
			begin
				case ({ctrl[BIT_GLOBAL_OUTPUT_INVERT], ctrl[BIT_DIR]})
					2'h0: next_pwm[3:0] = {raw[1], raw[0], 2'h0};
					2'h1: next_pwm[3:0] = {2'h0, raw[1], raw[0]};
					2'h2: next_pwm[3:0] = {2'h3, raw[1], raw[0]};
					2'h3: next_pwm[3:0] = {raw[1], raw[0], 2'h3};
					default: next_pwm[3:0] = BR_ALL_HIGH;
				endcase
			end
		end
	end

	// Output registers; reset gives the bridge-off pattern of the reset control value
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			pwm <= {2'h0, BR_HIGH_SIDE_OFF};
		end
		else
		begin
			pwm <= next_pwm;
		end
	end

	assign O_PWM = pwm;
	assign O_HRDATA = hrdata;
	assign O_HREADYOUT = 1'h1;
	assign O_HRESP = 1'h0;
	assign O_TRIP_IRQ = trip_pend;

	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RST_N);

	sequence bridge_live;
		ctrl[BIT_BRIDGE_MODE_ENABLE] && !ctrl[BIT_HIGH_SIDE_OFF] && ctrl[BIT_ENA];
	endsequence

	trip_shutdown_a: assert property (trip_hit |=> !ctrl[BIT_EN] && O_TRIP_IRQ)
		else $error("trip did not disable and flag");
	trip_clear_a: assert property (clri_wr && !trip_hit |=> !O_TRIP_IRQ)
		else $error("trip flag not cleared by write");
	sync_pulse_a: assert property (sync_fall && ctrl[BIT_SYNC] |=> sync_clear)
		else $error("sync edge not turned into restart");
	sync_ignore_a: assert property (!ctrl[BIT_SYNC] |=> !sync_clear)
		else $error("sync restart while disabled");
	tick_space_a: assert property (tick |=> !tick)
		else $error("prescaler stepped twice in a row");
	high_side_off_map_a: assert property (ctrl[BIT_BRIDGE_MODE_ENABLE] && ctrl[BIT_HIGH_SIDE_OFF] |=> O_PWM[3:0] == BR_HIGH_SIDE_OFF)
		else $error("high side off pattern wrong");
	ena_off_a: assert property (ctrl[BIT_BRIDGE_MODE_ENABLE] && !ctrl[BIT_HIGH_SIDE_OFF] && !ctrl[BIT_ENA]
		|=> O_PWM[3:0] == BR_ALL_HIGH)
		else $error("bridge disable pattern wrong");
	dir_map_a: assert property (bridge_live ##0 (!ctrl[BIT_GLOBAL_OUTPUT_INVERT] && ctrl[BIT_DIR])
		|=> O_PWM[3:2] == 2'h0 && O_PWM[1:0] == $past(raw[1:0]))
		else $error("direction map wrong");
	std_inv_a: assert property (!ctrl[BIT_BRIDGE_MODE_ENABLE] && ctrl[BIT_EN] && ctrl[BIT_INV1]
		|=> O_PWM[1] == !$past(ls_v[0]))
		else $error("output 1 not inverted");
	std_off_a: assert property (!ctrl[BIT_BRIDGE_MODE_ENABLE] && !ctrl[BIT_EN] |=> O_PWM == '0)
		else $error("outputs active while disabled");

endmodule : hbridge_pwm_unit

// [hdl/pwm_pkg.sv]
package pwm_pkg;

	// Register byte addresses on the bus
	localparam logic [31:0] CTRL_ADDR = 32'hFFFF0F80;
	localparam logic [31:0] PAIR_BASE = 32'hFFFF0F84;
	localparam logic [31:0] PAIR_SPAN = 32'h00000030;
	localparam logic [31:0] CLRI_ADDR = 32'hFFFF0FB8;
	localparam logic [31:0] STATUS_ADDR = 32'hFFFF0FBC;

	// Slices of the offset inside the pair window: 16 bytes per pair, 4 per word
	localparam int PIDX_MSB = 5;
	localparam int PIDX_LSB = 4;
	localparam int RIDX_MSB = 3;
	localparam int RIDX_LSB = 2;
	localparam int ALIGN_MSB = 1;
	localparam logic [1:0] LEN_IDX = 2'h3;

	// Control register reset value and writable bits (top bit is reserved)
	localparam logic [15:0] CTRL_RESET = 16'h0012;
	localparam logic [15:0] CTRL_WMASK = 16'h7FFF;

	// Control bit positions
	localparam int BIT_EN = 0;
	localparam int BIT_BRIDGE_MODE_ENABLE = 1;
	localparam int BIT_DIR = 2;
	localparam int BIT_LOAD_COMPARE_REQ = 3;
	localparam int BIT_HIGH_SIDE_OFF = 4;
	localparam int BIT_GLOBAL_OUTPUT_INVERT = 5;
	localparam int PRE_LSB = 6;
	localparam int PRE_MSB = 8;
	localparam int BIT_ENA = 9;
	localparam int BIT_TRIP = 10;
	localparam int BIT_INV1 = 11;
	localparam int BIT_INV3 = 12;
	localparam int BIT_INV5 = 13;
	localparam int BIT_SYNC = 14;

	// Status register bit
	localparam int BIT_TRIP_PEND = 0;

	// Structure
	localparam int NUM_PAIRS = 3;
	localparam int NUM_COMP = 3;
	localparam int NUM_OUT = 6;
	localparam int TIMER_W = 16;
	localparam int DIV_W = 8;

	// Compare slot roles inside one pair
	localparam int CMP_RISE_HS = 0;
	localparam int CMP_FALL_HS = 1;
	localparam int CMP_FALL_LS = 2;

	// Counting constants
	localparam logic [TIMER_W-1:0] TIMER_ZERO = 16'h0000;
	localparam logic [TIMER_W-1:0] TIMER_ONE = 16'h0001;
	localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
	localparam logic [DIV_W-1:0] DIV_ALL = 8'hFF;
	localparam logic [2:0] PRE_MAX = 3'h7;

	// Output patterns of the bridge outputs 3..0
	localparam logic [3:0] BR_ALL_HIGH = 4'hF;
	localparam logic [3:0] BR_HIGH_SIDE_OFF = 4'h5;

	// Bus
	localparam int HTRANS_ACT_BIT = 1;

endpackage : pwm_pkg

// [hdl/pair_if.sv]
`timescale 1ns/1ns
interface pair_if
	import pwm_pkg::*;
();
	logic tick; // Prescaled timer step
	logic sync_clear; // Counter restart from the sync pin
	logic load_req; // Copy programmed compares at the next 0 to 1 step
	logic [NUM_COMP-1:0][TIMER_W-1:0] com; // Programmed compare values
	logic [TIMER_W-1:0] len; // Period value
	logic hs; // High-side waveform
	logic ls; // Low-side waveform

	modport ctrl(output tick, output sync_clear, output load_req, output com, output len, input hs, input ls);
	modport pair(input tick, input sync_clear, input load_req, input com, input len, output hs, output ls);
endinterface : pair_if

// [hdl/pwm_pair.sv]
`timescale 1ns/1ns
module pwm_pair
	import pwm_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	pair_if.pair pio
);

	logic [TIMER_W-1:0] cnt; // Timer count
	logic [TIMER_W-1:0] next_cnt;
	logic [NUM_COMP-1:0][TIMER_W-1:0] cmp; // Internal compare values
	logic [NUM_COMP-1:0][TIMER_W-1:0] next_cmp;
	logic hs; // High-side level
	logic next_hs;
	logic ls; // Low-side level
	logic next_ls;

	// Timer, compare shadow and edge logic
	always_comb
	begin
		next_cnt = cnt;
		next_cmp = cmp;
		if (pio.sync_clear)
		begin
			// Sync restart has priority over a step
			next_cnt = TIMER_ZERO;
		end
		else if (pio.tick)
		begin
			if (cnt == pio.len)
			begin
				next_cnt = TIMER_ZERO;
			end
			else
			begin
				next_cnt = cnt + TIMER_ONE;
			end
			// Loading only at the 0 to 1 step keeps a period from seeing mixed values
			if (cnt == TIMER_ZERO && pio.load_req && pio.len != TIMER_ZERO)
			begin
				next_cmp = pio.com;
			end
		end
		next_hs = hs;
		if (cnt == cmp[CMP_FALL_HS])
		begin
			// Fall wins when both compares are equal
			next_hs = 1'h0;
		end
		else if (cnt == cmp[CMP_RISE_HS])
		begin
			next_hs = 1'h1;
		end
		next_ls = ls;
		if (cnt == cmp[CMP_FALL_LS] || (hs && !next_hs))
		begin
			next_ls = 1'h0;
		end
		else if (cnt == pio.len)
		begin
			next_ls = 1'h1;
		end
	end

	// Registers
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt <= '0;
			cmp <= '0;
			hs <= 1'h0;
			ls <= 1'h0;
		end
		else
		begin
			cnt <= next_cnt;
			cmp <= next_cmp;
			hs <= next_hs;
			ls <= next_ls;
		end
	end

	assign pio.hs = hs;
	assign pio.ls = ls;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence at_period_end;
		pio.tick && !pio.sync_clear && cnt == pio.len;
	endsequence

	period_wrap_a: assert property (at_period_end |=> cnt == TIMER_ZERO)
		else $error("timer did not restart after period");
	sync_zero_a: assert property (pio.sync_clear |=> cnt == TIMER_ZERO)
		else $error("sync did not clear timer");
	hs_rise_a: assert property (cnt == cmp[CMP_RISE_HS] && cnt != cmp[CMP_FALL_HS] |=> hs)
		else $error("high side did not rise at compare");
	hs_fall_a: assert property (cnt == cmp[CMP_FALL_HS] |=> !hs && !ls)
		else $error("high side fall not seen on outputs");
	ls_rise_a: assert property (cnt == pio.len && cnt != cmp[CMP_FALL_LS] && !(hs && cnt == cmp[CMP_FALL_HS])
		|=> ls)
		else $error("low side did not rise at period");
	cmp_load_a: assert property (pio.tick && !pio.sync_clear && cnt == TIMER_ZERO && pio.load_req
		&& pio.len != TIMER_ZERO |=> cmp == $past(pio.com))
		else $error("compare values not loaded");
	cmp_hold_a: assert property (!pio.load_req |=> $stable(cmp))
		else $error("compare values changed without load");

endmodule : pwm_pair

// [tb/bridge_load_model.sv]
`timescale 1ns/1ns
module bridge_load_model
	import pwm_pkg::*;
(
	input wire logic i_clk,
	input wire logic [NUM_OUT-1:0] i_pwm,
	input wire logic i_clear,
	input wire logic i_sync_run,
	input wire logic i_trip,
	output logic o_sync,
	output logic o_trip_n,
	output logic [NUM_OUT-1:0][15:0] o_on_cnt
);
	logic [2:0] phase = 3'h0; // Sync pulse phase, one falling edge every 8 clocks

	initial o_sync = 1'b1;

	// Sync idles high and pulses low only on request, so a stray fall never restarts the timers
	always @(posedge i_clk)
	begin
		phase <= phase + 3'h1;
		o_sync <= !(i_sync_run && phase[2]);
	end

	// Fault line of the load, low while a fault is requested
	assign o_trip_n = !i_trip;

	// On-time of each load in clocks; whole periods make the sum independent of phase
	always @(posedge i_clk)
	begin
		for (int k = 0; k < NUM_OUT; k++)
			o_on_cnt[k] <= i_clear ? 16'h0000 : o_on_cnt[k] + {15'h0000, i_pwm[k]};
	end
endmodule : bridge_load_model

// [tb/hbridge_pwm_unit_tb.sv]
`timescale 1ns/1ns
module hbridge_pwm_unit_tb
	import pwm_pkg::*;
;
	// On-time over 200 clocks at prescale code 0 (2 clocks per step)
	localparam logic [15:0] FULL = 16'h00C8; // Always high
	localparam logic [15:0] HS0 = 16'h003C; // Steps 2..4 of 10
	localparam logic [15:0] LS0 = 16'h0050; // Steps 9,0..2 of 10
	localparam logic [15:0] HS1 = 16'h0078; // Steps 1..6 of 10
	localparam logic [15:0] LS1 = 16'h0078; // Steps 9,0..4 of 10
	localparam logic [15:0] HS2 = 16'h0050; // Steps 1..2 of 5
	localparam logic [15:0] LS2 = 16'h0078; // Steps 4,0,1 of 5
	localparam logic [15:0] ZE = 16'h0000;
	localparam logic [NUM_OUT-1:0][15:0] STD = {LS2, HS2, LS1, HS1, LS0, HS0};
	// Bridge cases: ENA off, HIGH_SIDE_OFF, then GLOBAL_OUTPUT_INVERT/DIR 00,01,10,11, then ENA outside bridge mode
	localparam logic [15:0] BR_CTRL [7] = '{16'h000B, 16'h021B, 16'h020B, 16'h020F, 16'h022B, 16'h022F, 16'h0209};
	localparam logic [NUM_OUT-1:0][15:0] BR_EXP [7] = '{
		{LS2, HS2, FULL, FULL, FULL, FULL}, {LS2, HS2, ZE, FULL, ZE, FULL},
		{LS2, HS2, LS0, HS0, ZE, ZE}, {LS2, HS2, ZE, ZE, LS0, HS0},
		{FULL - LS2, FULL - HS2, FULL, FULL, LS0, HS0}, {FULL - LS2, FULL - HS2, LS0, HS0, FULL, FULL}, STD};

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata;
	logic hready; // Single slave: its ready is the bus ready
	logic hresp; // Bus response, expected OKAY on every transfer
	logic sync;
	logic trip_n;
	logic [NUM_OUT-1:0] pwm;
	logic irq;
	logic clear = 1'b1; // Holds the on-time counters at zero
	logic sync_run = 1'b0;
	logic trip = 1'b0;
	logic [NUM_OUT-1:0][15:0] on_cnt;
	logic [31:0] rd;
	int n_errors = 0;
	int tests_run = 0;

	always #5 clk = ~clk;

	hbridge_pwm_unit u_hbridge_pwm_unit (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
		.I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
		.O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_SYNC(sync), .I_TRIP_N(trip_n),
		.O_PWM(pwm), .O_TRIP_IRQ(irq));

	bridge_load_model u_bridge_load_model (.i_clk(clk), .i_pwm(pwm), .i_clear(clear), .i_sync_run(sync_run),
		.i_trip(trip), .o_sync(sync), .o_trip_n(trip_n), .o_on_cnt(on_cnt));

	// Prints the counts and the verdict, then stops
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	// Compares one word
	task automatic check32(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check32

	// Compares the on-time of all six loads
	task automatic check_on(input logic [NUM_OUT-1:0][15:0] exp);
		for (int k = 0; k < NUM_OUT; k++)
			check32({16'h0000, on_cnt[k]}, {16'h0000, exp[k]});
	endtask : check_on

	// Waits for a rising edge with ready high; a hung bus ends the run
	task automatic wait_ready();
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (hready !== 1'b1 && n < 16);
		if (hready !== 1'b1)
		begin
			n_errors++;
			give_verdict();
		end
	endtask : wait_ready

	// One single transfer; entered just after a rising edge
	task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= addr;
		hwrite <= wr;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wdata;
		wait_ready();
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [31:0] addr, input logic [31:0] data);
		bus(1'b1, addr, data);
	endtask : wr

	task automatic bus_rd(input logic [31:0] addr, input logic [31:0] exp);
		bus(1'b0, addr, 32'h00000000);
		check32(rd, exp);
		check32({31'h0, hresp}, 32'h00000000);
	endtask : bus_rd

	// Programs the three compares and the period of one pair
	task automatic set_pair(input int p, input logic [15:0] c0, c1, c2, len);
		wr(PAIR_BASE + 32'(p * 16), {16'h0000, c0});
		wr(PAIR_BASE + 32'(p * 16 + 4), {16'h0000, c1});
		wr(PAIR_BASE + 32'(p * 16 + 8), {16'h0000, c2});
		wr(PAIR_BASE + 32'(p * 16 + 12), {16'h0000, len});
	endtask : set_pair

	// Settles for n clocks, then counts on-time over the next n clocks
	task automatic measure(input int n);
		clear <= 1'b1;
		repeat (n) @(posedge clk);
		clear <= 1'b0;
		repeat (n) @(posedge clk);
		#1;
	endtask : measure

	// Bounded wait for the interrupt level
	task automatic wait_irq(input logic val);
		int n;
		n = 0;
		while (irq !== val && n < 50)
		begin
			@(posedge clk);
			n++;
		end
		check32({31'h0, irq}, {31'h0, val});
		// Only a real timeout ends the run early
		if (irq !== val)
			give_verdict();
	endtask : wait_irq

	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk);
		#1 check32({26'h0, pwm}, 32'h00000005);
		check32({31'h0, irq}, 32'h00000000);
		rst_n <= 1'b1;
		@(posedge clk);
		bus_rd(CTRL_ADDR, 32'h00000012);
		wr(32'hFFFF0FC0, 32'h0000FFFF);
		bus_rd(32'hFFFF0FC0, 32'h00000000);
		set_pair(0, 16'h0002, 16'h0005, 16'h0003, 16'h0009);
		set_pair(1, 16'h0001, 16'h0007, 16'h0005, 16'h0009);
		set_pair(2, 16'h0001, 16'h0003, 16'h0002, 16'h0004);
		bus_rd(PAIR_BASE + 32'h0000001C, 32'h00000009);
		wr(CTRL_ADDR, 32'h00000008);
		measure(200);
		check_on({ZE, ZE, ZE, ZE, ZE, ZE});
		wr(CTRL_ADDR, 32'h00000009);
		measure(200);
		check_on(STD);
		wr(CTRL_ADDR, 32'h00003809);
		measure(200);
		check_on({FULL - LS2, HS2, FULL - LS1, HS1, FULL - LS0, HS0});
		// New fall point must wait for the load request
		wr(CTRL_ADDR, 32'h00000001);
		wr(PAIR_BASE + 32'h00000004, 32'h00000007);
		// Pair 2 low side then ends only at its high-side fall
		wr(PAIR_BASE + 32'h00000028, 32'h00000007);
		measure(200);
		check32({16'h0000, on_cnt[0]}, {16'h0000, HS0});
		wr(CTRL_ADDR, 32'h00000009);
		measure(200);
		check32({16'h0000, on_cnt[0]}, 32'h00000064);
		check32({16'h0000, on_cnt[5]}, 32'h000000A0);
		wr(PAIR_BASE + 32'h00000004, 32'h00000005);
		wr(PAIR_BASE + 32'h00000028, 32'h00000002);
		// Step length doubles with each prescale code
		for (int c = 0; c < 8; c++)
		begin
			wr(CTRL_ADDR, 32'h00000009 | 32'(c << 6));
			measure(20 << (c + 1));
			check32({16'h0000, on_cnt[0]}, 32'(6 << (c + 1)));
		end
		// Sync falls every 8 clocks keep pair 0 below its fall compare once BIT_SYNC is set
		wr(CTRL_ADDR, 32'h00000009);
		sync_run <= 1'b1;
		measure(200);
		check32({16'h0000, on_cnt[0]}, {16'h0000, HS0});
		wr(CTRL_ADDR, 32'h00004009);
		measure(200);
		check32({16'h0000, on_cnt[0]}, {16'h0000, FULL});
		check32({16'h0000, on_cnt[1]}, 32'h00000000);
		sync_run <= 1'b0;
		for (int m = 0; m < 7; m++)
		begin
			wr(CTRL_ADDR, {16'h0000, BR_CTRL[m]});
			measure(200);
			check_on(BR_EXP[m]);
		end
		// Fault with trip enabled
		wr(CTRL_ADDR, 32'h00000409);
		trip <= 1'b1;
		wait_irq(1'b1);
		bus_rd(CTRL_ADDR, 32'h00000408);
		bus_rd(STATUS_ADDR, 32'h00000001);
		trip <= 1'b0;
		wr(CLRI_ADDR, 32'h00000000);
		wait_irq(1'b0);
		// Fault with trip disabled is ignored
		wr(CTRL_ADDR, 32'h00000009);
		trip <= 1'b1;
		repeat (20) @(posedge clk);
		check32({31'h0, irq}, 32'h00000000);
		bus_rd(CTRL_ADDR, 32'h00000009);
		trip <= 1'b0;
		give_verdict();
	end
endmodule : hbridge_pwm_unit_tb
